// ===== logic/ued_pkg.sv
// package: constants and types for the control endpoint support block
`default_nettype none

package ued_pkg;

	// ****************************************************************
	// bus geometry
	// ****************************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// register indices; byte address is four times the index
	// ****************************************************************
	localparam logic [7:0] IDX_SETUP0 = 8'hE0;
	localparam logic [7:0] IDX_SETUP7 = 8'hE7;
	localparam logic [7:0] IDX_ADDR   = 8'hE8;
	localparam logic [7:0] IDX_GUARD  = 8'hEA;
	localparam logic [7:0] IDX_FRAME  = 8'hEE;
	localparam logic [7:0] IDX_MAXPKT = 8'hF0;
	localparam logic [7:0] IDX_HSHK   = 8'hF4;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int HS_IN_STALL  = 0;
	localparam int HS_IN_NAK    = 1;
	localparam int HS_OUT_STALL = 2;
	localparam int HS_OUT_NAK   = 3;
	localparam int HS_TOG_IN    = 4;
	localparam int HS_TOG_OUT   = 5;
	localparam int FRAME_INV    = 15;
	localparam int MAXPKT_LSB   = 3;
	localparam int MAXPKT_MSB   = 6;

	// ****************************************************************
	// reset values and request decoding
	// ****************************************************************
	localparam logic [15:0] FRAME_RST  = 16'h8000;
	localparam logic [7:0]  MAXPKT_RST = 8'h40;
	localparam logic [7:0]  ADDR_RST   = 8'h00;
	localparam logic [7:0]  GUARD_RST  = 8'h00;
	localparam logic [7:0]  REQ_TYPE_SETADDR = 8'h00;
	localparam logic [7:0]  REQ_CODE_SETADDR = 8'h05;

	typedef enum {
		REG_NONE,
		REG_SETUP,
		REG_ADDR,
		REG_GUARD,
		REG_FRAME,
		REG_MAXPKT,
		REG_HSHK
	} ued_reg_t;

	// whole state of the block, registered as one word
	typedef struct packed {
		logic              aw_ok;
		logic [ADDR_W-1:0] waddr;
		logic              w_ok;
		logic [7:0]        wdata;
		logic              wlane0;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [DATA_W-1:0] rdata;
		logic [7:0][7:0]   setup;
		logic [6:0]        dev_addr;
		logic              pend_ok;
		logic [6:0]        pend_addr;
		logic              stored;
		logic              done;
		logic              protect;
		logic [1:0]        nak;
		logic [1:0]        stall;
		logic [1:0]        tog;
		logic [10:0]       frame;
		logic              finv;
		logic [3:0]        maxpkt;
	} ued_state_t;

endpackage : ued_pkg

`default_nettype wire

// ===== logic/ued_ctrl_ep.sv
// control endpoint setup capture, auto addressing and frame tracking
`default_nettype none

// Contract
// - on setup completion store all eight setup bytes in order, type first.
// - setup byte two is wValue low, byte three wValue high.
// - setup byte four is wIndex low, byte five wIndex high.
// - setup byte six is wLength low, byte seven wLength high.
// - a SetAddress request loads the new seven-bit address without software.
// - completion notice only after status stage ends and address is stored.
// - software may write the address; a later SetAddress overwrites it.
// - end of every setup stage sets the protect flag.
// - same cycle: stall bits cleared, NAK bits set, toggle bits set.
// - protect flag is set for SetAddress requests too.
// - while protected, writes to endpoint-zero NAK and stall are ignored.
// - every valid SOF loads the eleven-bit frame count; a bad SOF leaves it unchanged.
// - frame invalid bit 15 is one on a bad SOF, zero when valid.
// - frame register reads 8000h after reset until a valid SOF.
// - max packet size lives in bits 6..3, reset value gives 64 bytes.
module ued_ctrl_ep #(
	parameter int ADDR_W = 12
) (
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	// setup, status and SOF events from the packet engine
	input  wire logic               i_setup_valid,
	input  wire logic [63:0]        i_setup_data,
	input  wire logic               i_status_stage_done,
	input  wire logic               i_sof_valid,
	input  wire logic [10:0]        i_sof_frame,
	input  wire logic               i_sof_error,
	// state towards the packet engine
	output logic [6:0]              o_device_address,
	output logic                    o_address_assign_done,
	output logic                    o_ctrl_ep_protect,
	output logic [1:0]              o_forced_nak,
	output logic [1:0]              o_forced_stall,
	output logic [1:0]              o_toggle_status,
	output logic [10:0]             o_frame_count,
	output logic                    o_frame_invalid,
	output logic [3:0]              o_ctrl_ep_max_packet_field,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]  i_awaddr,
	input  wire logic               i_awvalid,
	output logic                    o_awready,
	input  wire logic [31:0]        i_wdata,
	input  wire logic [3:0]         i_wstrb,
	input  wire logic               i_wvalid,
	output logic                    o_wready,
	output logic [1:0]              o_bresp,
	output logic                    o_bvalid,
	input  wire logic               i_bready,
	input  wire logic [ADDR_W-1:0]  i_araddr,
	input  wire logic               i_arvalid,
	output logic                    o_arready,
	output logic [31:0]             o_rdata,
	output logic [1:0]              o_rresp,
	output logic                    o_rvalid,
	input  wire logic               i_rready
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (ADDR_W != ued_pkg::ADDR_W) begin : g_bad_addr_w
		$error("address width must match the package");
	end

	// ****************************************************************
	// decode
	// ****************************************************************
	function automatic ued_pkg::ued_reg_t reg_sel(
		input logic [ADDR_W-1:0] a
	);
		logic [7:0] idx;
		idx = a[9:2];
		reg_sel = ued_pkg::REG_NONE;
		if (a[1:0] == 2'h0 && a[ADDR_W-1:10] == '0) begin
			if (idx >= ued_pkg::IDX_SETUP0 && idx <= ued_pkg::IDX_SETUP7)
				reg_sel = ued_pkg::REG_SETUP;
			else if (idx == ued_pkg::IDX_ADDR)
				reg_sel = ued_pkg::REG_ADDR;
			else if (idx == ued_pkg::IDX_GUARD)
				reg_sel = ued_pkg::REG_GUARD;
			else if (idx == ued_pkg::IDX_FRAME)
				reg_sel = ued_pkg::REG_FRAME;
			else if (idx == ued_pkg::IDX_MAXPKT)
				reg_sel = ued_pkg::REG_MAXPKT;
			else if (idx == ued_pkg::IDX_HSHK)
				reg_sel = ued_pkg::REG_HSHK;
		end
	endfunction : reg_sel

	localparam ued_pkg::ued_state_t ST_RST = '{
		awready:  1'b1,
		wready:   1'b1,
		arready:  1'b1,
		dev_addr: ued_pkg::ADDR_RST[6:0],
		protect:  ued_pkg::GUARD_RST[0],
		frame:    ued_pkg::FRAME_RST[10:0],
		finv:     ued_pkg::FRAME_RST[ued_pkg::FRAME_INV],
		maxpkt:   ued_pkg::MAXPKT_RST[ued_pkg::MAXPKT_MSB:
		                              ued_pkg::MAXPKT_LSB],
		default:  '0
	};

	ued_pkg::ued_state_t st_q;
	ued_pkg::ued_state_t st_d;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		ued_pkg::ued_reg_t wsel;
		ued_pkg::ued_reg_t rsel;
		logic              wr_go;
		logic              is_setaddr;
		wsel = reg_sel(st_q.waddr);
		rsel = reg_sel(i_araddr);
		wr_go = 1'b0;
		is_setaddr = 1'b0;
		st_d = st_q;
		st_d.done = 1'b0;

		// write channels are taken independently, in either order
		if (i_awvalid && st_q.awready) begin
			st_d.aw_ok = 1'b1;
			st_d.waddr = i_awaddr;
		end
		if (i_wvalid && st_q.wready) begin
			st_d.w_ok = 1'b1;
			st_d.wdata = i_wdata[7:0];
			st_d.wlane0 = i_wstrb[0];
		end
		if (st_q.bvalid && i_bready)
			st_d.bvalid = 1'b0;
		if (st_q.aw_ok && st_q.w_ok && !st_q.bvalid) begin
			wr_go = st_q.wlane0;
			st_d.aw_ok = 1'b0;
			st_d.w_ok = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = (wsel == ued_pkg::REG_NONE) ?
				ued_pkg::RESP_SLVERR : ued_pkg::RESP_OKAY;
		end
		st_d.awready = !st_d.aw_ok;
		st_d.wready = !st_d.w_ok;

		// software writes; only byte lane zero carries register data
		if (wr_go) begin
			unique case (wsel)
				ued_pkg::REG_ADDR:
					st_d.dev_addr = st_q.wdata[6:0];
				ued_pkg::REG_GUARD:
					st_d.protect = st_q.wdata[0];
				ued_pkg::REG_MAXPKT:
					st_d.maxpkt = st_q.wdata[ued_pkg::MAXPKT_MSB:
					                        ued_pkg::MAXPKT_LSB];
				ued_pkg::REG_HSHK: begin
					// toggle bits follow software freely
					st_d.tog[0] = st_q.wdata[ued_pkg::HS_TOG_IN];
					st_d.tog[1] = st_q.wdata[ued_pkg::HS_TOG_OUT];
					if (!st_q.protect) begin
						st_d.stall[0] = st_q.wdata[ued_pkg::HS_IN_STALL];
						st_d.nak[0] = st_q.wdata[ued_pkg::HS_IN_NAK];
						st_d.stall[1] = st_q.wdata[ued_pkg::HS_OUT_STALL];
						st_d.nak[1] = st_q.wdata[ued_pkg::HS_OUT_NAK];
					end
				end
				default: ;
			endcase
		end

		// setup capture overrides a software guard or handshake write in the same cycle
		if (i_setup_valid) begin
			for (int i = 0; i < 8; i++)
				st_d.setup[i] = i_setup_data[8*i +: 8];
			st_d.protect = 1'b1;
			st_d.stall = 2'b00;
			st_d.nak = 2'b11;
			st_d.tog = 2'b11;
			is_setaddr =
				i_setup_data[7:0] == ued_pkg::REQ_TYPE_SETADDR &&
				i_setup_data[15:8] == ued_pkg::REQ_CODE_SETADDR;
			// a new setup replaces any unfinished address request
			st_d.pend_ok = is_setaddr;
			st_d.pend_addr = i_setup_data[22:16];
		end

		// address takes effect only once the status stage is over
		st_d.stored = 1'b0;
		if (i_status_stage_done && st_q.pend_ok && !i_setup_valid) begin
			st_d.dev_addr = st_q.pend_addr;
			st_d.pend_ok = 1'b0;
			st_d.stored = 1'b1;
		end
		st_d.done = st_q.stored;

		// frame tracking
		if (i_sof_valid) begin
			st_d.finv = i_sof_error;
			if (!i_sof_error)
				st_d.frame = i_sof_frame;
		end

		// read channel: one read outstanding at a time
		if (st_q.rvalid && i_rready)
			st_d.rvalid = 1'b0;
		if (i_arvalid && st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = ued_pkg::RESP_OKAY;
			st_d.rdata = '0;
			unique case (rsel)
				ued_pkg::REG_SETUP:
					st_d.rdata[7:0] = st_q.setup[i_araddr[4:2]];
				ued_pkg::REG_ADDR:
					st_d.rdata[6:0] = st_q.dev_addr;
				ued_pkg::REG_GUARD:
					st_d.rdata[0] = st_q.protect;
				ued_pkg::REG_FRAME: begin
					st_d.rdata[10:0] = st_q.frame;
					st_d.rdata[ued_pkg::FRAME_INV] = st_q.finv;
				end
				ued_pkg::REG_MAXPKT:
					st_d.rdata[ued_pkg::MAXPKT_MSB:
					           ued_pkg::MAXPKT_LSB] = st_q.maxpkt;
				ued_pkg::REG_HSHK: begin
					st_d.rdata[ued_pkg::HS_IN_STALL] = st_q.stall[0];
					st_d.rdata[ued_pkg::HS_IN_NAK] = st_q.nak[0];
					st_d.rdata[ued_pkg::HS_OUT_STALL] = st_q.stall[1];
					st_d.rdata[ued_pkg::HS_OUT_NAK] = st_q.nak[1];
					st_d.rdata[ued_pkg::HS_TOG_IN] = st_q.tog[0];
					st_d.rdata[ued_pkg::HS_TOG_OUT] = st_q.tog[1];
				end
				ued_pkg::REG_NONE:
					st_d.rresp = ued_pkg::RESP_SLVERR;
			endcase
		end
		st_d.arready = !st_d.rvalid;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			st_q <= ST_RST;
		else
			st_q <= st_d;
	end

	// ****************************************************************
	// outputs, all straight from the state register
	// ****************************************************************
	assign o_device_address = st_q.dev_addr;
	assign o_address_assign_done = st_q.done;
	assign o_ctrl_ep_protect = st_q.protect;
	assign o_forced_nak = st_q.nak;
	assign o_forced_stall = st_q.stall;
	assign o_toggle_status = st_q.tog;
	assign o_frame_count = st_q.frame;
	assign o_frame_invalid = st_q.finv;
	assign o_ctrl_ep_max_packet_field = st_q.maxpkt;
	assign o_awready = st_q.awready;
	assign o_wready = st_q.wready;
	assign o_bresp = st_q.bresp;
	assign o_bvalid = st_q.bvalid;
	assign o_arready = st_q.arready;
	assign o_rdata = st_q.rdata;
	assign o_rresp = st_q.rresp;
	assign o_rvalid = st_q.rvalid;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	a_setup_bytes01: assert property (
		i_setup_valid |=> st_q.setup[0] == $past(i_setup_data[7:0]) &&
			st_q.setup[1] == $past(i_setup_data[15:8]))
		else $error("setup type or code not stored");
	a_setup_value: assert property (
		i_setup_valid |=> {st_q.setup[3], st_q.setup[2]} ==
			$past(i_setup_data[31:16]))
		else $error("wValue bytes misplaced");
	a_setup_index: assert property (
		i_setup_valid |=> {st_q.setup[5], st_q.setup[4]} ==
			$past(i_setup_data[47:32]))
		else $error("wIndex bytes misplaced");
	a_setup_length: assert property (
		i_setup_valid |=> {st_q.setup[7], st_q.setup[6]} ==
			$past(i_setup_data[63:48]))
		else $error("wLength bytes misplaced");
	a_auto_address: assert property (
		i_setup_valid && i_setup_data[15:0] == 16'h0500
		##1 (!i_setup_valid && !i_status_stage_done) [*1]
		##1 i_status_stage_done && !i_setup_valid
		|=> o_device_address == $past(i_setup_data[22:16], 3))
		else $error("auto address not loaded");
	a_done_late: assert property (
		o_address_assign_done |-> $past(i_status_stage_done, 2) &&
			$stable(o_device_address))
		else $error("address notice before store");
	a_protect_set: assert property (
		i_setup_valid |=> o_ctrl_ep_protect)
		else $error("protect flag not set by setup");
	a_handshake_force: assert property (
		i_setup_valid |=> o_forced_nak == 2'h3 &&
			o_forced_stall == 2'h0 && o_toggle_status == 2'h3)
		else $error("handshake controls not forced");
	a_protect_hold: assert property (
		o_ctrl_ep_protect && !i_setup_valid |=>
			$stable(o_forced_nak) && $stable(o_forced_stall))
		else $error("handshake changed while protected");
	a_sof_update: assert property (
		i_sof_valid && !i_sof_error |=>
			o_frame_count == $past(i_sof_frame) && !o_frame_invalid)
		else $error("frame count not updated");
	a_sof_error: assert property (
		i_sof_valid && i_sof_error |=> o_frame_invalid)
		else $error("bad SOF not flagged");
	a_reset_frame: assert property (
		$past(i_rst) |-> o_frame_invalid && o_frame_count == 11'h000 &&
			o_ctrl_ep_max_packet_field == 4'h8)
		else $error("wrong reset values");
	a_reserved_zero: assert property (
		o_rvalid |-> o_rdata[31:16] == 16'h0000 &&
			o_rdata[14:11] == 4'h0)
		else $error("reserved read bits not zero");

	c_setaddr_done: cover property (o_address_assign_done);
	c_setup_write: cover property (i_setup_valid && st_q.aw_ok &&
		st_q.w_ok);
	c_bad_sof: cover property (i_sof_valid && i_sof_error);
	c_unmapped: cover property (o_rvalid &&
		o_rresp == ued_pkg::RESP_SLVERR);

endmodule : ued_ctrl_ep

`default_nettype wire

// ===== bench/ued_host_model.sv
// host-side model issuing setup, status and SOF events to the block
`default_nettype none

module ued_host_model (
	input  wire logic   i_clk_sys,
	output logic        o_setup_valid,
	output logic [63:0] o_setup_data,
	output logic        o_status_done,
	output logic        o_sof_valid,
	output logic [10:0] o_sof_frame,
	output logic        o_sof_error
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle payload is the inverse of the last one, so stale data
	// never passes for a fresh packet
	initial begin
		o_setup_valid = 1'b0;
		o_setup_data = 64'h0;
		o_status_done = 1'b0;
		o_sof_valid = 1'b0;
		o_sof_frame = 11'h0;
		o_sof_error = 1'b0;
	end

	task automatic send_setup(input logic [63:0] v);
		@(posedge i_clk_sys);
		o_setup_valid <= 1'b1;
		o_setup_data <= v;
		@(posedge i_clk_sys);
		o_setup_valid <= 1'b0;
		o_setup_data <= ~v;
	endtask : send_setup

	task automatic send_status();
		@(posedge i_clk_sys);
		o_status_done <= 1'b1;
		@(posedge i_clk_sys);
		o_status_done <= 1'b0;
	endtask : send_status

	task automatic send_sof(input logic [10:0] f, input logic e);
		@(posedge i_clk_sys);
		o_sof_valid <= 1'b1;
		o_sof_frame <= f;
		o_sof_error <= e;
		@(posedge i_clk_sys);
		o_sof_valid <= 1'b0;
		o_sof_frame <= ~f;
		o_sof_error <= ~e;
	endtask : send_sof

endmodule : ued_host_model

`default_nettype wire

// ===== bench/ued_ctrl_ep_tb_top.sv
// self-checking bench for the control endpoint support block
`default_nettype none

module ued_ctrl_ep_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, rst, sv, st, fv, fe, prot, done, finv;
	logic [63:0] sd, v;
	logic [10:0] ff, fcnt;
	logic [6:0]  dev_addr, na;
	logic [1:0]  nak, stall, tog, bresp, rresp;
	logic [3:0]  mps, wstrb;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  m_setup [8];
	int          fail_count, comparisons, m_addr, m_prot, m_hs, m_frame, m_max;

	ued_host_model host_u (
		.i_clk_sys(clk), .o_setup_valid(sv), .o_setup_data(sd),
		.o_status_done(st), .o_sof_valid(fv), .o_sof_frame(ff),
		.o_sof_error(fe)
	);

	ued_ctrl_ep #(.ADDR_W(12)) dut_u (
		.i_clk_sys(clk), .i_rst(rst), .i_setup_valid(sv),
		.i_setup_data(sd), .i_status_stage_done(st), .i_sof_valid(fv),
		.i_sof_frame(ff), .i_sof_error(fe), .o_device_address(dev_addr),
		.o_address_assign_done(done), .o_ctrl_ep_protect(prot),
		.o_forced_nak(nak), .o_forced_stall(stall), .o_toggle_status(tog),
		.o_frame_count(fcnt), .o_frame_invalid(finv),
		.o_ctrl_ep_max_packet_field(mps), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ****************************************
	// bus tasks and comparisons
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] x,
		input logic [3:0] s, input logic [1:0] er);
		logic [1:0] r;
		r = 2'h3;
		// one edge between transfers, so bready is never assigned twice
		@(posedge clk);
		awaddr <= a;
		wdata <= x;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		chk("bresp", er, r);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [1:0]  r;
		logic [31:0] x;
		r = 2'h3;
		x = 'x;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				r = rresp;
				x = rdata;
				rready <= 1'b0;
				break;
			end
		end
		chk("rresp", er, r);
		chk("rdata", e, x);
	endtask : rd

	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction : ba

	task automatic ww(input logic [7:0] i, input logic [31:0] x);
		wr(ba(i), x, 4'hF, ued_pkg::RESP_OKAY);
	endtask : ww

	task automatic rr(input logic [7:0] i, input logic [31:0] e);
		rd(ba(i), e, ued_pkg::RESP_OKAY);
	endtask : rr

	// every register and every state pin except the done notice against the model
	task automatic check_all();
		for (int i = 0; i < 8; i++)
			rr(ued_pkg::IDX_SETUP0 + 8'(i), 32'(m_setup[i]));
		rr(ued_pkg::IDX_ADDR, m_addr);
		rr(ued_pkg::IDX_GUARD, m_prot);
		rr(ued_pkg::IDX_FRAME, m_frame);
		rr(ued_pkg::IDX_MAXPKT, m_max);
		rr(ued_pkg::IDX_HSHK, m_hs);
		chk("addr_pin", m_addr, dev_addr);
		chk("protect_pin", m_prot, prot);
		chk("stall_pin", {m_hs[2], m_hs[0]}, stall);
		chk("nak_pin", {m_hs[3], m_hs[1]}, nak);
		chk("toggle_pin", {m_hs[5], m_hs[4]}, tog);
		chk("frame_pin", m_frame & 32'h7FF, fcnt);
		chk("invalid_pin", m_frame >> 15, finv);
		chk("maxpkt_pin", m_max >> 3, mps);
	endtask : check_all

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	initial begin
		#100000;
		fail_count++;
		test_done();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		fail_count = 0;
		comparisons = 0;
		rst = 1'b1;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		m_addr = 0;
		m_prot = 0;
		m_hs = 0;
		m_frame = 32'h8000;
		m_max = 32'h40;
		for (int i = 0; i < 8; i++) m_setup[i] = 8'h0;
		void'($urandom(50));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check_all();
		v = {$urandom, $urandom};
		ww(ued_pkg::IDX_ADDR, v[31:0] | 32'h80);
		m_addr = v[6:0];
		m_max = 8 << ($urandom % 4);
		ww(ued_pkg::IDX_MAXPKT, m_max);
		ww(ued_pkg::IDX_GUARD, 32'hFE);
		ww(ued_pkg::IDX_HSHK, v[63:32]);
		m_hs = v[37:32];
		wr(ba(ued_pkg::IDX_FRAME), 32'h7FF, 4'hF, ued_pkg::RESP_OKAY);
		wr(ba(ued_pkg::IDX_ADDR), 32'h11, 4'hE, ued_pkg::RESP_OKAY);
		wr(12'h3E0, 32'h1, 4'hF, ued_pkg::RESP_SLVERR);
		wr(12'h3A1, 32'h1, 4'hF, ued_pkg::RESP_SLVERR);
		rd(12'h3E0, 32'h0, ued_pkg::RESP_SLVERR);
		check_all();
		// class 80h request code 05h must not be taken as an address request
		for (int i = 0; i < 3; i++) begin
			v = {$urandom, $urandom};
			v[15:0] = (i == 0) ? 16'h0580 : {8'h06, v[7:0]};
			host_u.send_setup(v);
			for (int j = 0; j < 8; j++) m_setup[j] = v[8*j +: 8];
			m_prot = 1;
			m_hs = 32'h3A;
			check_all();
			d_write_hs(1);
			check_all();
			ww(ued_pkg::IDX_GUARD, 32'h0);
			m_prot = 0;
			d_write_hs(0);
			check_all();
		end
		host_u.send_status();
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			#1;
			chk("done", 0, done);
		end
		@(posedge clk);
		v = {$urandom, $urandom};
		v[15:0] = 16'h0500;
		na = v[22:16];
		// status right behind the setup, one idle cycle between them
		host_u.send_setup(v);
		host_u.send_status();
		#1;
		chk("addr_pin", na, dev_addr);
		chk("done", 0, done);
		@(posedge clk);
		#1;
		chk("done", 1, done);
		@(posedge clk);
		#1;
		chk("done", 0, done);
		@(posedge clk);
		for (int j = 0; j < 8; j++) m_setup[j] = v[8*j +: 8];
		m_prot = 1;
		m_hs = 32'h3A;
		m_addr = na;
		check_all();
		for (int i = 0; i < 6; i++) begin
			v = {$urandom, $urandom};
			host_u.send_sof(v[10:0], v[40:39] == 2'h0);
			m_frame = (v[40:39] == 2'h0) ? (m_frame | 32'h8000) : v[10:0];
			check_all();
		end
		test_done();
	end

	// handshake write; while protected only the toggles may change
	task automatic d_write_hs(input int p);
		logic [31:0] x;
		x = $urandom;
		ww(ued_pkg::IDX_HSHK, x);
		m_hs = p ? ((m_hs & 32'h0F) | (x & 32'h30)) : (x & 32'h3F);
	endtask : d_write_hs

endmodule : ued_ctrl_ep_tb_top

`default_nettype wire
